// ===== src/spg_pkg.sv
// Constants shared by the lane pattern generator and checker.
// Assumes a 16-bit management register port on the lane clock.
package spg_pkg;
    // Register addresses (management device 1)
    localparam logic [15:0] SPG_CHK_CTRL_ADDR = 16'hD0D1;
    localparam logic [15:0] SPG_GEN_CTRL_ADDR = 16'hD0E1;
    localparam logic [15:0] SPG_LOCK_ADDR = 16'hD0D9;
    localparam logic [15:0] SPG_CNT_HI_ADDR = 16'hD0DA;
    localparam logic [15:0] SPG_CNT_LO_ADDR = 16'hD0DB;
    // Writable bit masks, reserved bits stay zero
    localparam logic [15:0] SPG_GEN_WMASK = 16'h003F;
    localparam logic [15:0] SPG_CHK_WMASK = 16'h0EFF;
    // Reset values
    localparam logic [15:0] SPG_GEN_RST = 16'h000A;
    localparam logic [15:0] SPG_CHK_RST = 16'h002A;
    // Field positions
    localparam int SPG_EN_BIT = 0;
    localparam int SPG_POLY_LSB = 1;
    localparam int SPG_INV_BIT = 4;
    localparam int SPG_INS_BIT = 5;
    localparam int SPG_MODE_LSB = 5;
    localparam int SPG_AUTO_BIT = 7;
    localparam int SPG_BURST_BIT = 9;
    localparam int SPG_TRN_BIT = 10;
    localparam int SPG_CLKEN_BIT = 11;
    // Polynomial codes and lock modes
    localparam logic [2:0] SPG_POLY31 = 3'h5;
    localparam logic [2:0] SPG_POLY_RSVD = 3'h7;
    localparam logic [1:0] SPG_MODE_SELF = 2'h0;
    localparam logic [1:0] SPG_MODE_SEED = 2'h1;
    localparam logic [1:0] SPG_MODE_STICKY = 2'h2;
    // Shift register length and per-code length / second tap
    localparam int SPG_SR_W = 58;
    localparam int spg_len_c [0:6] = '{7, 9, 11, 15, 23, 31, 58};
    localparam int spg_tap_c [0:6] = '{6, 5, 9, 14, 18, 28, 39};
    // Lock hysteresis defaults, in words
    localparam int SPG_LOCK_GOOD = 4;
    localparam int SPG_LOCK_BAD = 4;
    typedef enum logic {SPG_SEARCH, SPG_LOCKED} spg_lock_type;
endpackage

// ===== src/spg_step.sv
// One word of pattern stepping, shared by generator and checker.
// Purely combinational; the caller registers the state.
`timescale 1ns/10ps
module spg_step #(
    parameter int DATA_W = 40
) (
    input wire logic [spg_pkg::SPG_SR_W-1:0] state_in, // Current state
    input wire logic [2:0] poly_in, // Polynomial code
    input wire logic [DATA_W-1:0] seed_in, // Received word
    output logic [DATA_W-1:0] word_out, // Predicted word
    output logic [spg_pkg::SPG_SR_W-1:0] free_out, // State, free run
    output logic [spg_pkg::SPG_SR_W-1:0] seed_out // State, from seed
);
    import spg_pkg::*;

    // Serial stepping, bit 0 first; reserved code runs as PRBS31
    always_comb begin
        logic [SPG_SR_W-1:0] s;
        logic [SPG_SR_W-1:0] r;
        int n;
        int t;
        logic b;
        s = state_in;
        r = state_in;
        n = spg_len_c[SPG_POLY31];
        t = spg_tap_c[SPG_POLY31];
        b = 1'b0;
        word_out = '0;
        if (poly_in != SPG_POLY_RSVD) begin
            n = spg_len_c[poly_in];
            t = spg_tap_c[poly_in];
        end
        for (int i = 0; i < DATA_W; i++) begin
            // R5 - taps per length
            b = s[n-1] ^ s[t-1];
            word_out[i] = b;
            s = {s[SPG_SR_W-2:0], b};
            r = {r[SPG_SR_W-2:0], seed_in[i]};
        end
        free_out = s;
        seed_out = r;
    end
endmodule

// ===== src/spg_top.sv
// Pattern generator and checker for the MAC-side serial lane.
// Assumes rx data, descrambler lock and training errors come from
// logic on clock_in; registers are reached by the management port.
// Function
// R1 - Reserved control bits ignore writes and read as zero
// R2 - Rising error-insert bit flips the output word MSB once
// R3 - Generator invert bit complements every output bit
// R4 - Generator polynomial codes 0..6, 7 reserved, reset to PRBS31
// R5 - 58-stage pattern uses taps 39 and 58
// R6 - Generator runs only while its enable is set, reset off
// R7 - Software sets checker clock enable before checker enable
// R8 - Training-sum mode reuses the error counter, no checking
// R9 - Burst mode counts one per burst, ended by clean word
// R10 - Default mode counts every mismatched bit
// R11 - Auto mode gates checker with descrambler lock
// R12 - Mode zero always reseeds from received bits
// R13 - Mode one seeds until lock; mode two holds lock
// R14 - Checker invert complements received data before checking
// R15 - Checker polynomial like generator, resets five, enable off
// R16 - Live read-only lock indication
// R17 - Each word compared to prediction, mismatches counted
`timescale 1ns/10ps
module spg_top #(
    parameter int DATA_W = 40,
    parameter int CNT_W = 32,
    parameter int LOCK_GOOD = spg_pkg::SPG_LOCK_GOOD,
    parameter int LOCK_BAD = spg_pkg::SPG_LOCK_BAD
) (
    input wire logic clock_in, // Lane word clock
    input wire logic sys_rst_in, // Sync reset, high
    input wire logic [15:0] reg_addr_in, // Register address
    input wire logic reg_wr_in, // Write strobe
    input wire logic [15:0] reg_wdata_in, // Write data
    input wire logic reg_rd_in, // Read strobe
    input wire logic [DATA_W-1:0] rx_data_in, // Received word
    input wire logic rx_dsc_lock_in, // Descrambler locked
    input wire logic trn_err_in, // Training-sum error pulse
    output logic [15:0] reg_rdata_out, // Read data
    output logic reg_rvalid_out, // Read data valid
    output logic [DATA_W-1:0] tx_data_out, // Transmit word
    output logic chk_lock_out // Checker locked
);
    import spg_pkg::*;

    logic [15:0] gen_ctrl_r, gen_ctrl_nxt, chk_ctrl_r, chk_ctrl_nxt;
    logic [15:0] reg_rdata_nxt;
    logic reg_rvalid_nxt;
    logic [SPG_SR_W-1:0] gen_sr_r, gen_sr_nxt, gen_free;
    logic [DATA_W-1:0] gen_word, gen_raw, tx_nxt;
    logic ins_prev_r, ins_prev_nxt, ins_pulse;
    logic [SPG_SR_W-1:0] chk_sr_r, chk_sr_nxt, chk_free, chk_seed;
    logic [DATA_W-1:0] chk_word, rx_eff, mism;
    spg_lock_type lock_r, lock_nxt;
    logic [7:0] good_r, good_nxt, bad_r, bad_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic prev_bad_r, prev_bad_nxt, act_prev_r, act_prev_nxt;
    logic chk_active, word_bad, gen_en, chk_en;
    logic [$clog2(DATA_W+1)-1:0] pop;
    logic [1:0] lmode;

    assign gen_en = gen_ctrl_r[SPG_EN_BIT];
    assign chk_en = chk_ctrl_r[SPG_EN_BIT];
    assign lmode = chk_ctrl_r[SPG_MODE_LSB +: 2];
    // R11 - auto enable gating
    // R8 - no checking in training-sum mode
    // R7 - clock force bit must be on as well
    assign chk_active = chk_en && chk_ctrl_r[SPG_CLKEN_BIT] &&
        !chk_ctrl_r[SPG_TRN_BIT] &&
        (!chk_ctrl_r[SPG_AUTO_BIT] || rx_dsc_lock_in);

    // Register writes and registered reads
    always_comb begin
        gen_ctrl_nxt = gen_ctrl_r;
        chk_ctrl_nxt = chk_ctrl_r;
        reg_rdata_nxt = 16'h0000;
        reg_rvalid_nxt = reg_rd_in;
        // R1 - reserved bits masked off
        if (reg_wr_in && reg_addr_in == SPG_GEN_CTRL_ADDR) begin
            gen_ctrl_nxt = reg_wdata_in & SPG_GEN_WMASK;
        end
        if (reg_wr_in && reg_addr_in == SPG_CHK_CTRL_ADDR) begin
            chk_ctrl_nxt = reg_wdata_in & SPG_CHK_WMASK;
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                SPG_GEN_CTRL_ADDR: reg_rdata_nxt = gen_ctrl_r;
                SPG_CHK_CTRL_ADDR: reg_rdata_nxt = chk_ctrl_r;
                // R16 - live lock state
                SPG_LOCK_ADDR: begin
                    reg_rdata_nxt = {15'h0000, lock_r == SPG_LOCKED};
                end
                SPG_CNT_HI_ADDR: reg_rdata_nxt = 16'(cnt_r >> 16);
                SPG_CNT_LO_ADDR: reg_rdata_nxt = cnt_r[15:0];
                default: reg_rdata_nxt = 16'h0000;
            endcase
        end
    end

    // R4 - polynomial field resets to PRBS31
    // R15 - checker enable off, polynomial five
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            gen_ctrl_r <= SPG_GEN_RST;
            chk_ctrl_r <= SPG_CHK_RST;
            reg_rdata_out <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            gen_ctrl_r <= gen_ctrl_nxt;
            chk_ctrl_r <= chk_ctrl_nxt;
            reg_rdata_out <= reg_rdata_nxt;
            reg_rvalid_out <= reg_rvalid_nxt;
        end
    end

    spg_step #(.DATA_W(DATA_W)) u_gen_step (
        .state_in(gen_sr_r),
        .poly_in(gen_ctrl_r[SPG_POLY_LSB +: 3]),
        .seed_in('0),
        .word_out(gen_word),
        .free_out(gen_free),
        .seed_out()
    );

    // R3 - invert whole word
    assign gen_raw = gen_word ^ {DATA_W{gen_ctrl_r[SPG_INV_BIT]}};
    // R2 - edge, not level, inserts an error
    assign ins_pulse = gen_ctrl_r[SPG_INS_BIT] && !ins_prev_r;

    // Generator stepping; idle output is all zeros
    always_comb begin
        gen_sr_nxt = gen_sr_r;
        tx_nxt = '0;
        ins_prev_nxt = gen_ctrl_r[SPG_INS_BIT];
        // R6 - run only when enabled
        if (gen_en) begin
            gen_sr_nxt = gen_free;
            tx_nxt = gen_raw;
            // R2 - flip the MSB once
            tx_nxt[DATA_W-1] = gen_raw[DATA_W-1] ^ ins_pulse;
        end
    end

    // All-ones seed: any state with a one among its low polynomial-length bits keeps the sequence alive
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            gen_sr_r <= '1;
            tx_data_out <= '0;
            ins_prev_r <= 1'b0;
        end else begin
            gen_sr_r <= gen_sr_nxt;
            tx_data_out <= tx_nxt;
            ins_prev_r <= ins_prev_nxt;
        end
    end

    // R14 - invert ahead of the checker
    assign rx_eff = rx_data_in ^ {DATA_W{chk_ctrl_r[SPG_INV_BIT]}};

    spg_step #(.DATA_W(DATA_W)) u_chk_step (
        .state_in(chk_sr_r),
        .poly_in(chk_ctrl_r[SPG_POLY_LSB +: 3]),
        .seed_in(rx_eff),
        .word_out(chk_word),
        .free_out(chk_free),
        .seed_out(chk_seed)
    );

    // R17 - compare against prediction
    assign mism = rx_eff ^ chk_word;
    assign word_bad = |mism;

    // Mismatch population count
    always_comb begin
        pop = '0;
        for (int i = 0; i < DATA_W; i++) begin
            pop = pop + {{($bits(pop)-1){1'b0}}, mism[i]};
        end
    end

    // Lock machine, seed path and error counter
    always_comb begin
        lock_nxt = lock_r;
        chk_sr_nxt = chk_sr_r;
        good_nxt = good_r;
        bad_nxt = bad_r;
        cnt_nxt = cnt_r;
        prev_bad_nxt = 1'b0;
        act_prev_nxt = chk_active;
        if (chk_active) begin
            prev_bad_nxt = word_bad;
            good_nxt = word_bad ? 8'h00 : good_r + 8'h01;
            bad_nxt = word_bad ? bad_r + 8'h01 : 8'h00;
            case (lock_r)
                SPG_SEARCH: begin
                    chk_sr_nxt = chk_seed;
                    if (!word_bad && good_r >= 8'(LOCK_GOOD - 1)) begin
                        lock_nxt = SPG_LOCKED;
                        bad_nxt = 8'h00;
                    end
                end
                SPG_LOCKED: begin
                    // R12 - self-sync keeps reseeding
                    // R13 - seed modes run free once locked
                    chk_sr_nxt = (lmode == SPG_MODE_SELF) ? chk_seed
                                                          : chk_free;
                    // R13 - mode two never drops lock
                    if (word_bad && bad_r >= 8'(LOCK_BAD - 1) &&
                        lmode != SPG_MODE_STICKY) begin
                        lock_nxt = SPG_SEARCH;
                        good_nxt = 8'h00;
                    end
                    if (chk_ctrl_r[SPG_BURST_BIT]) begin
                        // R9 - one count per burst
                        if (word_bad && !prev_bad_r && cnt_r != '1) begin
                            cnt_nxt = cnt_r + 1'b1;
                        end
                    end else if (word_bad) begin
                        // R10 - one count per bit, saturating
                        cnt_nxt = ({1'b0, cnt_r} + (CNT_W+1)'(pop) >
                                   {1'b0, {CNT_W{1'b1}}}) ? '1 :
                                  cnt_r + CNT_W'(pop);
                    end
                end
                default: lock_nxt = SPG_SEARCH;
            endcase
            // Fresh count at each checker start
            if (!act_prev_r) begin
                cnt_nxt = '0;
            end
        end else begin
            lock_nxt = SPG_SEARCH;
            good_nxt = 8'h00;
            bad_nxt = 8'h00;
        end
        // R8 - counter counts training-sum errors
        if (chk_ctrl_r[SPG_TRN_BIT] && trn_err_in && cnt_r != '1) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            lock_r <= SPG_SEARCH;
            chk_sr_r <= '1;
            good_r <= 8'h00;
            bad_r <= 8'h00;
            cnt_r <= '0;
            prev_bad_r <= 1'b0;
            act_prev_r <= 1'b0;
            chk_lock_out <= 1'b0;
        end else begin
            lock_r <= lock_nxt;
            chk_sr_r <= chk_sr_nxt;
            good_r <= good_nxt;
            bad_r <= bad_nxt;
            cnt_r <= cnt_nxt;
            prev_bad_r <= prev_bad_nxt;
            act_prev_r <= act_prev_nxt;
            chk_lock_out <= (lock_nxt == SPG_LOCKED);
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_ins_edge;
        gen_en && ins_pulse;
    endsequence

    a_rsvd_bits_zero: assert property ( // R1
        gen_ctrl_r[15:6] == 10'h000 && chk_ctrl_r[15:12] == 4'h0 &&
        !chk_ctrl_r[8]) else $error("reserved control bit set");
    a_err_ins_msb: assert property ( // R2
        s_ins_edge |=> tx_data_out[DATA_W-1] != $past(gen_raw[DATA_W-1])
    ) else $error("error insert missed");
    a_gen_word_clean: assert property ( // R3
        gen_en && !ins_pulse |=> tx_data_out == $past(gen_raw)
    ) else $error("generator word corrupted");
    a_poly_reset_val: assert property ( // R4
        @(posedge clock_in) disable iff (1'b0)
        sys_rst_in |=> gen_ctrl_r[3:1] == SPG_POLY31 &&
        chk_ctrl_r[3:1] == SPG_POLY31) else $error("poly reset wrong");
    a_gen_off_idle: assert property ( // R6
        !gen_en ##1 !gen_en |=> tx_data_out == '0 && $stable(gen_sr_r)
    ) else $error("generator ran while off");
    a_auto_gate: assert property ( // R11
        chk_ctrl_r[SPG_AUTO_BIT] && !rx_dsc_lock_in |=> lock_r == SPG_SEARCH
    ) else $error("checker active without lock");
    a_sticky_lock: assert property ( // R13
        lock_r == SPG_LOCKED && lmode == SPG_MODE_STICKY && chk_active
        |=> lock_r == SPG_LOCKED) else $error("mode two lost lock");
    a_burst_single: assert property ( // R9
        chk_active && act_prev_r && lock_r == SPG_LOCKED &&
        chk_ctrl_r[SPG_BURST_BIT] && word_bad && prev_bad_r &&
        !chk_ctrl_r[SPG_TRN_BIT] |=> $stable(cnt_r)
    ) else $error("burst counted twice");
    a_bit_count: assert property ( // R10
        chk_active && act_prev_r && lock_r == SPG_LOCKED &&
        !chk_ctrl_r[SPG_BURST_BIT] && cnt_r < 32'(CNT_W'(1) << (CNT_W-1))
        |=> cnt_r == $past(cnt_r) + CNT_W'($past(pop))
    ) else $error("bit count wrong");
    a_lock_status: assert property ( // R16
        reg_rd_in && reg_addr_in == SPG_LOCK_ADDR
        |=> reg_rdata_out == {15'h0000, $past(lock_r) == SPG_LOCKED}
    ) else $error("lock status mismatch");
endmodule

// ===== verif/spg_link_partner.sv
// Link partner model: loops each transmit word back as the received word.
// Assumes one lane clock; the bench commands bit flips on the wire.
`timescale 1ns/10ps
module spg_link_partner #(
    parameter int DATA_W = 40
) (
    input wire logic clock_in, // Lane word clock
    input wire logic sys_rst_in, // Sync reset, high
    input wire logic [DATA_W-1:0] tx_data_in, // Word from the device
    input wire logic [DATA_W-1:0] flip_in, // Bits to corrupt
    output logic [DATA_W-1:0] rx_data_out // Word back to the device
);
    // One word of wire delay, so the checker never sees a zero-latency path
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            rx_data_out <= '0;
        end else begin
            rx_data_out <= tx_data_in ^ flip_in;
        end
    end
endmodule

// ===== verif/serdes_prbs_gen_checker_test.sv
// Bench for the lane pattern generator and checker.
// Assumes the partner model loops tx back to rx, with commanded flips.
`timescale 1ns/10ps
module serdes_prbs_gen_checker_test;
    import spg_pkg::*;
    localparam int DW = 40;
    logic clock_in, sys_rst_in, reg_wr, reg_rd, dsc_lock, trn_err;
    logic [15:0] reg_addr, reg_wdata, rdata;
    logic rvalid, lock_o;
    logic [DW-1:0] rx_data, tx_data, flip, first;
    logic [119:0] hist;
    logic [31:0] c0, c1;
    int fail_count, samples_checked, nz;
    int lens [0:7] = '{7, 9, 11, 15, 23, 31, 58, 31};
    int taps [0:7] = '{6, 5, 9, 14, 18, 28, 39, 28};

    spg_top #(.DATA_W(DW)) dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata),
        .reg_rd_in(reg_rd), .rx_data_in(rx_data), .rx_dsc_lock_in(dsc_lock),
        .trn_err_in(trn_err), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .tx_data_out(tx_data), .chk_lock_out(lock_o));
    spg_link_partner #(.DATA_W(DW)) link (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .tx_data_in(tx_data), .flip_in(flip),
        .rx_data_out(rx_data));

    // Free-running lane clock, 8 ns period
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    // Last three transmit words, oldest in the low bits
    always @(posedge clock_in) hist <= {tx_data, hist[119:40]};

    // Newest-word bits breaking b[k] = b[k-n] ^ b[k-t], ^1 if inverted
    function automatic logic [39:0] viol(logic [119:0] h, int n, int t,
        logic inv);
        logic [39:0] m;
        for (int j = 0; j < 40; j++) begin
            m[j] = h[80+j] ^ h[80+j-n] ^ h[80+j-t] ^ inv;
        end
        return m;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("mismatches=%0d compares=%0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock_in);
        reg_wr <= 1'b0;
    endtask

    // Read data stands for the one cycle after the strobe edge
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clock_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock_in);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
        check(rvalid, 1'b1);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        check(d, e);
    endtask

    // Counter halves are not latched, so counts are kept small
    task automatic rd_cnt(output logic [31:0] c);
        logic [15:0] h, l;
        rd(SPG_CNT_HI_ADDR, h);
        rd(SPG_CNT_LO_ADDR, l);
        c = {h, l};
    endtask

    task automatic watch(input int cyc, input int n, input int t,
        input logic inv);
        logic [39:0] m;
        nz = 0;
        first = '0;
        repeat (cyc) begin
            @(posedge clock_in);
            #1;
            m = viol(hist, n, t, inv);
            if (m !== 40'h0) begin
                if (nz == 0) first = m;
                nz++;
            end
        end
    endtask

    task automatic wait_lock(input logic v);
        int k;
        k = 0;
        while (lock_o !== v && k < 100) begin
            @(posedge clock_in);
            #1;
            k++;
        end
        check(lock_o, v);
        if (k == 100) close_out();
    endtask

    task automatic flip_words(input logic [39:0] m, input int w);
        @(posedge clock_in);
        flip <= m;
        repeat (w) @(posedge clock_in);
        flip <= '0;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clock_in);
        fail_count++;
        close_out();
    end

    initial begin
        {reg_wr, reg_rd, trn_err} = '0;
        {reg_addr, reg_wdata, flip} = '0;
        {dsc_lock, sys_rst_in} = 2'h3;
        fail_count = 0;
        samples_checked = 0;
        repeat (20) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rd_chk(SPG_GEN_CTRL_ADDR, 16'h000A);
        rd_chk(SPG_CHK_CTRL_ADDR, 16'h002A);
        rd_chk(SPG_LOCK_ADDR, 16'h0000);
        rd_chk(16'h1234, 16'h0000);
        check(tx_data, 64'h0);
        wr(SPG_GEN_CTRL_ADDR, 16'hFFFF);
        rd_chk(SPG_GEN_CTRL_ADDR, 16'h003F);
        wr(SPG_CHK_CTRL_ADDR, 16'hFFFF);
        rd_chk(SPG_CHK_CTRL_ADDR, 16'h0EFF);
        wr(SPG_CHK_CTRL_ADDR, 16'h0000);
        // Every polynomial code, checked against its own recurrence
        for (int p = 0; p < 8; p++) begin
            wr(SPG_GEN_CTRL_ADDR, 16'(p * 2 + 1));
            repeat (6) @(posedge clock_in);
            watch(4, lens[p], taps[p], 1'b0);
            check(nz, 0);
        end
        wr(SPG_GEN_CTRL_ADDR, 16'h001B);
        repeat (6) @(posedge clock_in);
        watch(4, 31, 28, 1'b1);
        check(nz, 0);
        watch(2, 31, 28, 1'b0);
        check(first, {DW{1'b1}});
        wr(SPG_GEN_CTRL_ADDR, 16'h000A);
        repeat (3) @(posedge clock_in);
        check(tx_data, 64'h0);
        wr(SPG_GEN_CTRL_ADDR, 16'h000B);
        repeat (6) @(posedge clock_in);
        // Error word plus its tap echoes one word later; a held level adds none
        for (int i = 0; i < 2; i++) begin
            wr(SPG_GEN_CTRL_ADDR, 16'h002B);
            watch(8, 31, 28, 1'b0);
            check(first, 64'h80_0000_0000);
            check(nz, 2);
            wr(SPG_GEN_CTRL_ADDR, 16'h000B);
        end
        wr(SPG_CHK_CTRL_ADDR, 16'h082B);
        wait_lock(1'b1);
        rd_chk(SPG_LOCK_ADDR, 16'h0001);
        rd_cnt(c0);
        wr(SPG_GEN_CTRL_ADDR, 16'h002B);
        flip_words(40'h7, 2);
        repeat (10) @(posedge clock_in);
        rd_cnt(c1);
        check(c1 - c0, 64'd7);
        wr(SPG_CHK_CTRL_ADDR, 16'h0A2B);
        flip_words(40'h7, 2);
        flip_words(40'h7, 1);
        flip_words(40'h7, 1);
        repeat (10) @(posedge clock_in);
        rd_cnt(c0);
        check(c0 - c1, 64'd3);
        wr(SPG_CHK_CTRL_ADDR, 16'h082B);
        flip_words({DW{1'b1}}, 8);
        wait_lock(1'b0);
        wait_lock(1'b1);
        wr(SPG_CHK_CTRL_ADDR, 16'h084B);
        flip_words({DW{1'b1}}, 8);
        repeat (4) @(posedge clock_in);
        check(lock_o, 1'b1);
        wr(SPG_CHK_CTRL_ADDR, 16'h080A);
        repeat (3) @(posedge clock_in);
        check(lock_o, 1'b0);
        wr(SPG_CHK_CTRL_ADDR, 16'h080B);
        wait_lock(1'b1);
        // Reseeding from rx echoes an MSB error at taps 28 and 31
        rd_cnt(c0);
        flip_words(40'h80_0000_0000, 1);
        repeat (10) @(posedge clock_in);
        rd_cnt(c1);
        check(c1 - c0, 64'd3);
        wr(SPG_CHK_CTRL_ADDR, 16'h080A);
        wr(SPG_GEN_CTRL_ADDR, 16'h001B);
        wr(SPG_CHK_CTRL_ADDR, 16'h082B);
        repeat (30) @(posedge clock_in);
        check(lock_o, 1'b0);
        wr(SPG_CHK_CTRL_ADDR, 16'h083B);
        wait_lock(1'b1);
        wr(SPG_GEN_CTRL_ADDR, 16'h000B);
        wr(SPG_CHK_CTRL_ADDR, 16'h082A);
        @(posedge clock_in) dsc_lock <= 1'b0;
        wr(SPG_CHK_CTRL_ADDR, 16'h08AB);
        repeat (30) @(posedge clock_in);
        check(lock_o, 1'b0);
        @(posedge clock_in) dsc_lock <= 1'b1;
        wait_lock(1'b1);
        @(posedge clock_in) dsc_lock <= 1'b0;
        wait_lock(1'b0);
        wr(SPG_CHK_CTRL_ADDR, 16'h0C2B);
        repeat (3) @(posedge clock_in);
        check(lock_o, 1'b0);
        rd_cnt(c0);
        repeat (5) begin
            @(posedge clock_in) trn_err <= 1'b1;
            @(posedge clock_in) trn_err <= 1'b0;
        end
        repeat (3) @(posedge clock_in);
        rd_cnt(c1);
        check(c1 - c0, 64'd5);
        close_out();
    end
endmodule
